/* File: logic/cpu_core_pkg.sv */
package cpu_core_pkg;

  // Program and data organisation.
  localparam int          PC_W         = 13;
  localparam int          IP_W         = 7;
  localparam int          ROM_W        = 10;
  localparam int          RAM_W        = 4;
  localparam int          STACK_DEPTH  = 8;
  localparam logic [2:0]  SP_RESET     = 3'h7;
  localparam logic [12:0] VEC_BASE     = 13'h0080;
  localparam logic [12:0] SPECIAL_BASE = 13'h0100;
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [6:0]  IP_LAST      = 7'h7F;

  // Timing: one machine cycle is three system clocks at a 4 ns period.
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          MC_CLKS       = 3;
  localparam logic [1:0]  MC_LAST       = 2'(MC_CLKS - 1);
  localparam logic [1:0]  IRQ_LATENCY   = 2'h2;

  // Register byte offsets.
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_PC    = 8'h08;
  localparam logic [7:0] OFF_DP    = 8'h0C;
  localparam logic [7:0] OFF_IRQ   = 8'h10;
  localparam logic [7:0] OFF_CTX   = 8'h14;
  localparam logic [7:0] OFF_TABLE = 8'h18;
  localparam logic [7:0] OFF_PORT  = 8'h1C;

  // Field positions.
  localparam int CMD_ARG_LSB  = 8;
  localparam int CMD_TWO_BIT  = 15;
  localparam int CMD_TGT_LSB  = 16;
  localparam int IRQ_EN_LSB   = 8;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_IMM, OP_ADD_MEM, OP_ADD_MEM_C, OP_ROT_RC, OP_SET_C, OP_CLR_C,
    OP_LOAD_A, OP_LOAD_B, OP_LOAD_D, OP_E_TO_BA, OP_BA_TO_E, OP_TABLE_READ,
    OP_IDX_BRANCH, OP_IDX_CALL, OP_BRANCH, OP_CALL, OP_SPECIAL_CALL, OP_RETURN,
    OP_RETURN_INT, OP_READ_SP, OP_IRQ_EN, OP_IRQ_DIS, OP_IRQ_TEST, OP_RAM_SET,
    OP_RAM_CLR, OP_RAM_TEST, OP_PORT_SET, OP_PORT_CLR, OP_PORT_TEST
  } op_t;

  typedef struct packed {
    logic [1:0] z;
    logic [3:0] x;
    logic [3:0] y;
  } dp_t;

  typedef struct packed {
    dp_t        dp;
    logic       carry;
    logic       skip;
    logic [3:0] acc;
    logic [3:0] aux;
  } ctx_t;

  typedef struct packed {
    logic [3:0] wdata;
    logic       we;
    dp_t        addr;
  } ram_req_t;

endpackage

/* File: logic/cpu_state_sequencer_core.sv */
// Implementation choices: the address map and register access over AHB-Lite.
module cpu_state_sequencer_core (
  // Clock and reset.
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave.
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  // Program ROM read port.
  output logic [cpu_core_pkg::PC_W-1:0]      rom_addr,
  input  wire logic [cpu_core_pkg::ROM_W-1:0] rom_data,
  // Data RAM port.
  output cpu_core_pkg::ram_req_t             ram_req,
  input  wire logic [cpu_core_pkg::RAM_W-1:0] ram_rdata,
  // Interrupt events and power state.
  input  wire logic [7:0]                    irq_event,
  input  wire logic                          backup_exit,
  // Output port bits selected by the digit field.
  output logic [15:0]                        port_bits
);
  import cpu_core_pkg::*;

  typedef enum logic {ST_RUN, ST_TABLE} state_t;

  // Lowest index wins, which gives external 0 the top priority.
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [1:0]      mc_cnt_q;
  logic            mc_en;
  logic            wr_pend_q;
  logic [7:0]      wr_off_q;
  logic [31:0]     hrdata_q;
  logic            cmd_valid_q;
  logic [31:0]     cmd_q;
  op_t             cmd_op;
  logic [5:0]      cmd_arg;
  logic [PC_W-1:0] cmd_tgt;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_seq;
  logic [3:0]      acc_q;
  logic [3:0]      aux_q;
  logic [7:0]      e_q;
  logic [2:0]      d_q;
  logic            carry_q;
  logic            skip_q;
  logic [2:0]      sp_q;
  logic            global_irq_enable_q;
  ctx_t            ctx_q;
  dp_t             dp_q;
  state_t          state_q;
  logic [7:0]      table_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [7:0]      flags_q;
  logic [7:0]      irq_en_q;
  logic [7:0]      irq_ready;
  logic [2:0]      irq_src;
  logic [1:0]      irq_cnt_q;
  logic            take_irq;
  logic            exec;
  logic            run_op;
  logic            push;
  logic [PC_W-1:0] push_val;
  logic [7:0]      irq_clr;
  logic [4:0]      sum;
  logic            ram_bit;
  logic            port_bit;
  logic            irq_bit;

  // Machine-cycle divider; sequencing and interrupt entry wait for this enable, but not the backup-exit stack pointer reset, bus writes or request flags.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_cnt_q <= 2'h0;
    end else begin
      mc_cnt_q <= (mc_cnt_q == MC_LAST) ? 2'h0 : mc_cnt_q + 2'h1;
    end
  end
  assign mc_en = (mc_cnt_q == MC_LAST);

  // Bus slave answers with no wait states and always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Address phase capture; read data is prepared here so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_off_q  <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          OFF_CMD:   hrdata_q <= cmd_q;
          OFF_STATE: hrdata_q <= {13'h0000, cmd_valid_q, state_q == ST_TABLE, global_irq_enable_q, sp_q,
                                  d_q, skip_q, carry_q, aux_q, acc_q};
          OFF_PC:    hrdata_q <= {19'h00000, pc_q};
          OFF_DP:    hrdata_q <= {22'h000000, dp_q};
          OFF_IRQ:   hrdata_q <= {16'h0000, irq_en_q, flags_q};
          OFF_CTX:   hrdata_q <= {12'h000, ctx_q};
          OFF_TABLE: hrdata_q <= {16'h0000, e_q, table_q};
          OFF_PORT:  hrdata_q <= {16'h0000, port_bits};
          default:   hrdata_q <= 32'h0000_0000;
        endcase
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // Command slot; a write while a command is still pending is dropped, so poll busy first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_valid_q <= 1'b0;
      cmd_q       <= 32'h0000_0000;
    end else if (wr_pend_q && wr_off_q == OFF_CMD && !cmd_valid_q) begin
      cmd_valid_q <= 1'b1;
      cmd_q       <= hwdata;
    end else if (exec) begin
      cmd_valid_q <= 1'b0;
    end
  end

  assign cmd_op  = op_t'(cmd_q[4:0]);
  assign cmd_arg = cmd_q[CMD_ARG_LSB +: 6];
  assign cmd_tgt = cmd_q[CMD_TGT_LSB +: PC_W];
  assign pc_seq  = pc_q + (cmd_q[CMD_TWO_BIT] ? 13'h0002 : 13'h0001);

  // Interrupt gating and latency count in machine cycles.
  assign irq_ready = flags_q & irq_en_q & {8{global_irq_enable_q}};
  assign irq_src   = first_set(irq_ready);
  // The live gate is checked again here, since a disable may land after the count filled.
  assign take_irq  = mc_en && state_q == ST_RUN && irq_cnt_q == IRQ_LATENCY &&
                     irq_ready != 8'h00;
  assign exec      = mc_en && state_q == ST_RUN && cmd_valid_q && !take_irq;
  assign run_op    = exec && !skip_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_cnt_q <= 2'h0;
    end else if (mc_en) begin
      if (take_irq || irq_ready == 8'h00) begin
        irq_cnt_q <= 2'h0;
      end else if (irq_cnt_q != IRQ_LATENCY) begin
        irq_cnt_q <= irq_cnt_q + 2'h1;
      end
    end
  end

  // Operand bits picked by the digit field or the argument.
  assign ram_bit  = ram_rdata[cmd_arg[1:0]];
  assign port_bit = port_bits[dp_q.y];
  assign irq_bit  = flags_q[cmd_arg[2:0]] && !irq_en_q[cmd_arg[2:0]];
  assign sum      = {1'b0, acc_q} + {1'b0, ram_rdata} + {4'h0, carry_q};

  // Request flags; a new event in the clearing cycle keeps the flag set.
  always_comb begin
    irq_clr = 8'h00;
    if (take_irq) begin
      irq_clr[irq_src] = 1'b1;
    end
    if (run_op && cmd_op == OP_IRQ_TEST && irq_bit) begin
      irq_clr[cmd_arg[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= (flags_q & ~irq_clr) | irq_event;
    end
  end

  // Enable bits live in the interrupt register; one bit per source in bits 15:8, above the request flags.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= 8'h00;
    end else if (wr_pend_q && wr_off_q == OFF_IRQ) begin
      irq_en_q <= hwdata[IRQ_EN_LSB +: 8];
    end
  end

  // Return stack storage; no reset because levels are only read after a push.
  assign push = take_irq || (run_op && (cmd_op == OP_CALL || cmd_op == OP_SPECIAL_CALL ||
                cmd_op == OP_IDX_CALL || cmd_op == OP_TABLE_READ));
  assign push_val = take_irq ? pc_q : pc_seq;

  always_ff @(posedge hclk) begin
    if (push) begin
      stack_q[sp_q + 3'h1] <= push_val;
    end
  end

  // Data pointer: software loads it, interrupt return restores it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= '0;
    end else if (run_op && cmd_op == OP_RETURN_INT) begin
      dp_q <= ctx_q.dp;
    end else if (wr_pend_q && wr_off_q == OFF_DP) begin
      dp_q <= hwdata[9:0];
    end
  end

  // RAM bit writes are a read-modify-write of the addressed word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_req <= '0;
    end else begin
      ram_req.addr <= dp_q;
      ram_req.we   <= run_op && (cmd_op == OP_RAM_SET || cmd_op == OP_RAM_CLR);
      ram_req.wdata <= ram_rdata;
      ram_req.wdata[cmd_arg[1:0]] <= (cmd_op == OP_RAM_SET);
    end
  end

  // Port output latch bits addressed by the digit field.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_bits <= 16'h0000;
    end else if (run_op && (cmd_op == OP_PORT_SET || cmd_op == OP_PORT_CLR)) begin
      port_bits[dp_q.y] <= (cmd_op == OP_PORT_SET);
    end
  end

  // Core sequencing: interrupt entry, command execution and table read completion.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q     <= PC_RESET;
      acc_q    <= 4'h0;
      aux_q    <= 4'h0;
      e_q      <= 8'h00;
      d_q      <= 3'h0;
      carry_q  <= 1'b0;
      skip_q   <= 1'b0;
      sp_q     <= SP_RESET;
      global_irq_enable_q   <= 1'b0;
      ctx_q    <= '0;
      state_q  <= ST_RUN;
      table_q  <= 8'h00;
      rom_addr <= PC_RESET;
    end else begin
      if (take_irq) begin
        ctx_q   <= '{dp: dp_q, carry: carry_q, skip: skip_q, acc: acc_q, aux: aux_q};
        skip_q  <= 1'b0;
        global_irq_enable_q  <= 1'b0;
        sp_q    <= sp_q + 3'h1;
        pc_q    <= VEC_BASE | {9'h000, irq_src, 1'b0};
      end else if (mc_en && state_q == ST_TABLE) begin
        table_q <= rom_data[7:0];
        aux_q   <= rom_data[7:4];
        acc_q   <= rom_data[3:0];
        pc_q    <= stack_q[sp_q];
        sp_q    <= sp_q - 3'h1;
        state_q <= ST_RUN;
      end else if (exec && skip_q) begin
        skip_q <= 1'b0;
        pc_q   <= pc_seq;
      end else if (run_op) begin
        pc_q   <= pc_seq;
        skip_q <= 1'b0;
        case (cmd_op)
          OP_ADD_IMM:   acc_q <= acc_q + cmd_arg[3:0];
          OP_ADD_MEM:   acc_q <= acc_q + ram_rdata;
          OP_ADD_MEM_C: begin
            acc_q   <= sum[3:0];
            carry_q <= sum[4];
          end
          OP_ROT_RC: begin
            acc_q   <= {carry_q, acc_q[3:1]};
            carry_q <= acc_q[0];
          end
          OP_SET_C:     carry_q <= 1'b1;
          OP_CLR_C:     carry_q <= 1'b0;
          OP_LOAD_A:    acc_q <= cmd_arg[3:0];
          OP_LOAD_B:    aux_q <= cmd_arg[3:0];
          OP_LOAD_D:    d_q <= cmd_arg[2:0];
          OP_E_TO_BA: begin
            aux_q <= e_q[7:4];
            acc_q <= e_q[3:0];
          end
          OP_BA_TO_E:   e_q <= {aux_q, acc_q};
          OP_TABLE_READ: begin
            sp_q     <= sp_q + 3'h1;
            rom_addr <= {cmd_arg, d_q, acc_q};
            state_q  <= ST_TABLE;
          end
          OP_IDX_BRANCH: pc_q <= {cmd_arg, d_q, acc_q};
          OP_IDX_CALL: begin
            sp_q <= sp_q + 3'h1;
            pc_q <= {cmd_arg, d_q, acc_q};
          end
          OP_BRANCH:    pc_q <= cmd_tgt;
          OP_CALL: begin
            sp_q <= sp_q + 3'h1;
            pc_q <= cmd_tgt;
          end
          OP_SPECIAL_CALL: begin
            sp_q <= sp_q + 3'h1;
            pc_q <= SPECIAL_BASE | {6'h00, cmd_tgt[IP_W-1:0]};
          end
          OP_RETURN: begin
            pc_q <= stack_q[sp_q];
            sp_q <= sp_q - 3'h1;
          end
          OP_RETURN_INT: begin
            pc_q    <= stack_q[sp_q];
            sp_q    <= sp_q - 3'h1;
            carry_q <= ctx_q.carry;
            skip_q  <= ctx_q.skip;
            acc_q   <= ctx_q.acc;
            aux_q   <= ctx_q.aux;
          end
          OP_READ_SP:   acc_q <= {1'b0, sp_q};
          OP_IRQ_EN:    global_irq_enable_q <= 1'b1;
          OP_IRQ_DIS:   global_irq_enable_q <= 1'b0;
          OP_IRQ_TEST:  skip_q <= irq_bit;
          OP_RAM_TEST:  skip_q <= !ram_bit;
          OP_PORT_TEST: skip_q <= !port_bit;
          default: begin
          end
        endcase
      end
      if (backup_exit) begin
        sp_q <= SP_RESET;
      end
    end
  end

  // Checks next to the sequencer.
  a_mc_period: assert property (@(posedge hclk) disable iff (!hresetn)
    mc_en |=> !mc_en ##1 !mc_en ##1 mc_en) else $error("machine cycle is not three clocks");

  a_carry_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    run_op && (cmd_op == OP_ADD_IMM || cmd_op == OP_ADD_MEM) && !take_irq |=> $stable(carry_q))
    else $error("plain add changed carry");

  a_carry_amc: assert property (@(posedge hclk) disable iff (!hresetn)
    run_op && cmd_op == OP_ADD_MEM_C |=> carry_q == $past(sum[4])) else $error("carry lost");

  a_rot_carry: assert property (@(posedge hclk) disable iff (!hresetn)
    run_op && cmd_op == OP_ROT_RC |=> carry_q == $past(acc_q[0])) else $error("rotate carry");

  a_call_push: assert property (@(posedge hclk) disable iff (!hresetn)
    run_op && cmd_op == OP_CALL && !backup_exit |=>
    sp_q == $past(sp_q) + 3'h1 && pc_q == $past(cmd_tgt))
    else $error("call did not push");

  a_ctx_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    run_op && (cmd_op == OP_CALL || cmd_op == OP_TABLE_READ) |=> $stable(ctx_q))
    else $error("context written by call");

  a_irq_cond: assert property (@(posedge hclk) disable iff (!hresetn)
    take_irq |-> global_irq_enable_q && (flags_q[irq_src] && irq_en_q[irq_src])) else $error("bad irq");

  a_irq_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    take_irq |=> !global_irq_enable_q && pc_q[12:7] == 6'h01 && !pc_q[0] && pc_q[3:1] == $past(irq_src))
    else $error("interrupt entry state wrong");

  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    take_irq |=> flags_q == (($past(flags_q) & ~(8'h01 << $past(irq_src))) | $past(irq_event)))
    else $error("wrong request flags cleared");

  a_irq_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    (mc_en && irq_ready != 8'h00 && irq_cnt_q == 2'h0) ##1 (irq_ready != 8'h00)[*8]
    |-> ##[0:1] take_irq || state_q == ST_TABLE || irq_cnt_q != 2'h0)
    else $error("interrupt not taken in time");

  a_backup_sp: assert property (@(posedge hclk) disable iff (!hresetn)
    backup_exit |=> sp_q == SP_RESET) else $error("stack pointer not reset");

  c_irq_taken: cover property (@(posedge hclk) disable iff (!hresetn) take_irq);
  c_table_done: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_TABLE ##1 state_q == ST_RUN);
  c_sp_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    sp_q == 3'h7 ##1 sp_q == 3'h0);

endmodule

/* File: sim/rom_ram_model.sv */
// Program ROM and data RAM on the far side of the sequencer core.
module rom_ram_model
  import cpu_core_pkg::*;
(
  // Clock.
  input  wire logic                          hclk,
  // ROM port.
  input  wire logic [cpu_core_pkg::PC_W-1:0] rom_addr,
  output logic [cpu_core_pkg::ROM_W-1:0]     rom_data,
  // RAM port.
  input  cpu_core_pkg::ram_req_t             ram_req,
  output logic [cpu_core_pkg::RAM_W-1:0]     ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_core_pkg::*;

  logic [RAM_W-1:0] mem [1024];

  // Every word starts at all ones, so an add with carry from memory carries out whenever acc or carry is nonzero.
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 4'hF;
  end

  // Ten-bit words; the low byte is an offset of the address so table data is known.
  always_comb rom_data = {2'h3, 8'(rom_addr[7:0] + 8'h1E)};

  // Four-bit words, written on the core's one-clock strobe.
  always_comb ram_rdata = mem[ram_req.addr];
  always @(posedge hclk) begin
    if (ram_req.we) mem[ram_req.addr] <= ram_req.wdata;
  end
endmodule

/* File: sim/cpu_state_sequencer_core_test.sv */
// Register-driven bench for the sequencer core.
module cpu_state_sequencer_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_core_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, backup_exit;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [PC_W-1:0] rom_addr;
  logic [ROM_W-1:0] rom_data;
  ram_req_t ram_req;
  logic [RAM_W-1:0] ram_rdata;
  logic [7:0] irq_event;
  logic [15:0] port_bits;
  int failures, checks_done, cycles;

  assign hready = hreadyout;

  cpu_state_sequencer_core cpu_state_sequencer_core_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rom_addr(rom_addr),
    .rom_data(rom_data), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .irq_event(irq_event), .backup_exit(backup_exit), .port_bits(port_bits));

  rom_ram_model rom_ram_model_i (
    .hclk(hclk), .rom_addr(rom_addr), .rom_data(rom_data),
    .ram_req(ram_req), .ram_rdata(ram_rdata));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // A hung handshake would stall the run forever, so cap the cycle count.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single AHB transfer; read data is taken at the data-phase edge.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    ahb(1'b1, a, wd, x);
  endtask

  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0, d);
  endtask

  // Issue one command and poll until neither busy nor table read stands.
  task automatic cmd(input op_t op, input logic [5:0] arg, input logic [12:0] tgt);
    wr(OFF_CMD, {3'h0, tgt, 2'h0, arg, 3'h0, 5'(op)});
    for (int i = 0; i < 40; i++) begin
      rd(OFF_STATE);
      if (d[18:17] === 2'h0) break;
    end
    chk(d[18:17], 32'h0);
  endtask

  initial begin
    {hsel, hwrite, backup_exit} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    irq_event = 8'h00;
    hresetn = 1'b0;
    cycles = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFF_STATE);
    chk(d, 32'h0000E000);
    chk(hresp, 32'h0);
    $display("test reset done");
    // Carry arithmetic: memory words are all ones, so the add carries out.
    cmd(OP_LOAD_A, 6'h01, 13'h0);
    cmd(OP_CLR_C, 6'h00, 13'h0);
    cmd(OP_ADD_MEM_C, 6'h00, 13'h0);
    chk(d & 32'h1FF, 32'h100);
    cmd(OP_ADD_IMM, 6'h02, 13'h0);
    chk(d & 32'h1FF, 32'h102);
    cmd(OP_ROT_RC, 6'h00, 13'h0);
    chk(d & 32'h1FF, 32'h009);
    cmd(OP_SET_C, 6'h00, 13'h0);
    chk(d & 32'h100, 32'h100);
    $display("test carry done");
    // Nine nested calls wrap the pointer round to level zero.
    for (int i = 0; i < 9; i++) begin
      cmd(OP_CALL, 6'h00, 13'(13'h0200 + i));
      chk(d[15:13], 32'(i % 8));
    end
    rd(OFF_PC);
    chk(d, 32'h0208);
    cmd(OP_READ_SP, 6'h00, 13'h0);
    chk(d[3:0], 32'h0);
    backup_exit <= 1'b1;
    @(posedge hclk);
    backup_exit <= 1'b0;
    rd(OFF_STATE);
    chk(d[15:13], 32'h7);
    $display("test stack done");
    // Table read from {arg, pointer, acc} = 0x0A5, data byte 0xC3.
    cmd(OP_LOAD_A, 6'h05, 13'h0);
    cmd(OP_LOAD_D, 6'h02, 13'h0);
    cmd(OP_TABLE_READ, 6'h01, 13'h0);
    chk(d & 32'hE0FF, 32'hE0C3);
    rd(OFF_TABLE);
    chk(d[7:0], 32'hC3);
    $display("test table done");
    // Two enabled requests raised with interrupts globally off.
    wr(OFF_IRQ, 32'h0500);
    irq_event <= 8'h05;
    @(posedge hclk);
    irq_event <= 8'h00;
    rd(OFF_IRQ);
    chk(d, 32'h0505);
    cmd(OP_IRQ_EN, 6'h00, 13'h0);
    repeat (12) @(posedge hclk);
    rd(OFF_PC);
    chk(d, 32'h0080);
    rd(OFF_IRQ);
    chk(d, 32'h0504);
    rd(OFF_STATE);
    chk(d & 32'h1E000, 32'h0);
    rd(OFF_CTX);
    chk(d, 32'h023C);
    cmd(OP_RETURN_INT, 6'h00, 13'h0);
    cmd(OP_IRQ_EN, 6'h00, 13'h0);
    repeat (12) @(posedge hclk);
    rd(OFF_PC);
    chk(d, 32'h0084);
    rd(OFF_IRQ);
    chk(d, 32'h0500);
    $display("test interrupt done");
    // Disabled source is observed by the skip test, which clears its flag.
    irq_event <= 8'h08;
    @(posedge hclk);
    irq_event <= 8'h00;
    cmd(OP_IRQ_TEST, 6'h03, 13'h0);
    chk(d[9], 32'h1);
    rd(OFF_IRQ);
    chk(d, 32'h0500);
    $display("test skip done");
    // Bit operations on the word and port bit picked by digit field 5.
    wr(OFF_DP, 32'h0005);
    cmd(OP_PORT_SET, 6'h00, 13'h0);
    chk(d[9], 32'h0);
    cmd(OP_PORT_SET, 6'h00, 13'h0);
    chk(port_bits, 32'h0020);
    cmd(OP_PORT_TEST, 6'h00, 13'h0);
    chk(d[9], 32'h0);
    cmd(OP_RAM_CLR, 6'h00, 13'h0);
    cmd(OP_RAM_TEST, 6'h00, 13'h0);
    chk(d[9], 32'h1);
    $display("test bits done");
    results();
  end
endmodule
